// *** asrc_pkg.sv ***
package asrc_pkg;
   // Address and data widths of the memory
   localparam int ASRC_ADDR_W = 13;
   localparam int ASRC_DATA_W = 8;
   localparam int ASRC_DEPTH = 8192;
   // Clock period and device timing, ns
   localparam int ASRC_CLK_PERIOD_NS = 10;
   localparam int ASRC_T_READ_CYCLE_NS = 35;
   localparam int ASRC_T_WE_PULSE_NS = 20;
   localparam int ASRC_T_SETUP_DATA_NS = 12;
   localparam int ASRC_T_STROBE_TO_FLOAT_NS = 8;
   localparam int ASRC_T_FLOAT_NS = 10;
   // Least times round up to whole cycles
   localparam int ASRC_RD_CYC = (ASRC_T_READ_CYCLE_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
   localparam int ASRC_WE_CYC_RAW = (ASRC_T_STROBE_TO_FLOAT_NS + ASRC_T_SETUP_DATA_NS + ASRC_CLK_PERIOD_NS - 1)
      / ASRC_CLK_PERIOD_NS;
   localparam int ASRC_WEP_CYC = (ASRC_T_WE_PULSE_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
   localparam int ASRC_WE_CYC = (ASRC_WE_CYC_RAW > ASRC_WEP_CYC) ? ASRC_WE_CYC_RAW : ASRC_WEP_CYC;
   localparam int ASRC_FLT_CYC = (ASRC_T_FLOAT_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
   localparam logic [3:0] ASRC_CNT_ZERO = 4'h0;
   // Reset values of the pin outputs (all inactive)
   localparam logic ASRC_RST_SEL_N = 1'b1;
   localparam logic ASRC_RST_SEL_H = 1'b0;
   localparam logic ASRC_RST_WE_N = 1'b1;
   localparam logic ASRC_RST_OE_N = 1'b1;

   typedef struct packed {
      logic write;
      logic [ASRC_ADDR_W-1:0] addr;
      logic [ASRC_DATA_W-1:0] wdata;
   } asrc_req_t;

   typedef struct packed {
      logic select_active_low;
      logic select_active_high;
      logic write_strobe_n;
      logic output_gate_n;
      logic [ASRC_ADDR_W-1:0] addr;
   } asrc_pins_t;

   typedef enum logic [4:0] {
      ASRC_IDLE  = 5'b00001,
      ASRC_READ  = 5'b00010,
      ASRC_WRITE = 5'b00100,
      ASRC_WEND  = 5'b01000,
      ASRC_FLOAT = 5'b10000
   } asrc_state_t;
endpackage

// *** asrc_host.sv ***
// Summary of operation
// - Write data set-up and hold count from the edge that ends the write.
// - For a read the strobe stays high while both selects are on and the gate is low.
// - The host never drives the byte lines while the memory may be driving them.
// - A strobe-ended write, with the gate held high, lasts at least float delay plus data set-up.
`timescale 1ns/1ps
`default_nettype none
module asrc_host
   import asrc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // User request side
   input wire asrc_req_t req,
   input wire logic req_valid,
   output logic req_ready,
   output logic [ASRC_DATA_W-1:0] rdata,
   output logic rdata_valid,
   // Memory pins
   output var asrc_pins_t pins,
   input wire logic [ASRC_DATA_W-1:0] byte_lines_in,
   output logic [ASRC_DATA_W-1:0] byte_lines_out,
   output logic byte_lines_oe_n
);
   asrc_state_t state_q;
   logic [3:0] cnt_q;
   logic write_q;
   logic [ASRC_DATA_W-1:0] sync1_q;
   logic [ASRC_DATA_W-1:0] sync2_q;

   function automatic logic [3:0] cyc(input int n);
      cyc = 4'(n - 1);
   endfunction

   ////////////////////////////////////////////////////////////
   // Byte line input synchroniser
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end
      else
      begin
         sync1_q <= byte_lines_in;
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= ASRC_IDLE;
         cnt_q <= ASRC_CNT_ZERO;
         write_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            ASRC_IDLE:
            begin
               if (req_valid)
               begin
                  write_q <= req.write;
                  state_q <= req.write ? ASRC_WRITE : ASRC_READ;
                  // Extra cycles cover the two-stage input sampling
                  cnt_q <= req.write ? cyc(ASRC_WE_CYC) : cyc(ASRC_RD_CYC + 2);
               end
            end
            ASRC_READ, ASRC_WRITE:
            begin
               if (cnt_q != ASRC_CNT_ZERO)
                  cnt_q <= cnt_q - 4'h1;
               else
               begin
                  state_q <= write_q ? ASRC_WEND : ASRC_FLOAT;
                  cnt_q <= cyc(ASRC_FLT_CYC);
               end
            end
            ASRC_WEND:
               state_q <= ASRC_IDLE;
            ASRC_FLOAT:
            begin
               if (cnt_q != ASRC_CNT_ZERO)
                  cnt_q <= cnt_q - 4'h1;
               else
                  state_q <= ASRC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // Pin drive
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pins.select_active_low <= ASRC_RST_SEL_N;
         pins.select_active_high <= ASRC_RST_SEL_H;
         pins.write_strobe_n <= ASRC_RST_WE_N;
         pins.output_gate_n <= ASRC_RST_OE_N;
         pins.addr <= '0;
         byte_lines_out <= 8'h00;
         byte_lines_oe_n <= 1'b1;
      end
      else if (state_q == ASRC_IDLE && req_valid)
      begin
         // Address and data set up in the same edge as the write start
         pins.addr <= req.addr;
         pins.select_active_low <= 1'b0;
         pins.select_active_high <= 1'b1;
         pins.write_strobe_n <= !req.write;
         pins.output_gate_n <= req.write;
         byte_lines_out <= req.wdata;
         byte_lines_oe_n <= !req.write;
      end
      else if ((state_q == ASRC_READ || state_q == ASRC_WRITE) && cnt_q == ASRC_CNT_ZERO)
      begin
         // Strobe alone ends the write; selects fall one cycle later so data hold counts from it
         pins.write_strobe_n <= 1'b1;
         pins.output_gate_n <= 1'b1;
         if (!write_q)
         begin
            pins.select_active_low <= 1'b1;
            pins.select_active_high <= 1'b0;
         end
      end
      else if (state_q == ASRC_WEND)
      begin
         // Selects drop in the same edge that releases the data; gate still high, so no output turn-on
         pins.select_active_low <= 1'b1;
         pins.select_active_high <= 1'b0;
         byte_lines_oe_n <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////
   // User answers
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         req_ready <= 1'b0;
         rdata <= 8'h00;
         rdata_valid <= 1'b0;
      end
      else
      begin
         req_ready <= (state_q == ASRC_IDLE) && !req_valid;
         rdata_valid <= 1'b0;
         if (state_q == ASRC_READ && cnt_q == ASRC_CNT_ZERO)
         begin
            rdata <= sync2_q;
            rdata_valid <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Checks
   sequence s_write_start;
      $fell(pins.write_strobe_n);
   endsequence

   sequence s_write_release;
      $rose(pins.write_strobe_n) && write_q;
   endsequence

   sequence s_read_end;
      $rose(pins.output_gate_n);
   endsequence

   // Write pulse and data path
   a_no_contention: assert property (@(posedge sys_clk) disable iff (!nrst)
      !byte_lines_oe_n |-> pins.output_gate_n)
      else $error("host drives byte lines with gate low");
   a_write_width: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_write_start |-> !pins.write_strobe_n [*2])
      else $error("write strobe too short");
   a_write_driven: assert property (@(posedge sys_clk) disable iff (!nrst)
      !pins.write_strobe_n |-> pins.output_gate_n && !byte_lines_oe_n)
      else $error("strobe low without write data");
   a_data_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_write_release |-> !byte_lines_oe_n)
      else $error("data released with strobe");
   a_data_steady: assert property (@(posedge sys_clk) disable iff (!nrst)
      !byte_lines_oe_n && !$past(byte_lines_oe_n) |-> $stable(byte_lines_out))
      else $error("write data moved while driven");
   a_addr_steady: assert property (@(posedge sys_clk) disable iff (!nrst)
      !pins.select_active_low && !$past(pins.select_active_low) |-> $stable(pins.addr))
      else $error("address moved during access");
   a_sel_after_we: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_write_release |-> !pins.select_active_low ##1 pins.select_active_low)
      else $error("select not released after strobe");
   a_write_selected: assert property (@(posedge sys_clk) disable iff (!nrst)
      !pins.write_strobe_n |-> !pins.select_active_low && pins.select_active_high)
      else $error("strobe without select");

   // Read path
   a_read_strobe: assert property (@(posedge sys_clk) disable iff (!nrst)
      !pins.output_gate_n |-> pins.write_strobe_n)
      else $error("strobe low during read");
   a_read_data: assert property (@(posedge sys_clk) disable iff (!nrst)
      $fell(pins.output_gate_n) |-> ##[4:6] rdata_valid)
      else $error("read answer late");
   a_one_answer: assert property (@(posedge sys_clk) disable iff (!nrst)
      rdata_valid |=> !rdata_valid)
      else $error("read answer longer than one cycle");
   // Memory may still drive for its float time after the gate closes
   a_read_float: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_read_end |-> byte_lines_oe_n [*2])
      else $error("host drives before memory floats");

   // Select pairing and idle
   a_sel_pair: assert property (@(posedge sys_clk) disable iff (!nrst)
      pins.select_active_low == !pins.select_active_high)
      else $error("selects disagree");
   a_idle_deselect: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_q == ASRC_IDLE |-> pins.select_active_low && byte_lines_oe_n)
      else $error("selected while idle");
   a_float_end: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(pins.select_active_low) |-> byte_lines_oe_n || $past(write_q))
      else $error("float order");
endmodule
`default_nettype wire

// *** asrc_sram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model
   import asrc_pkg::*;
(
   // Control and address from the host
   input wire asrc_pins_t pins,
   input wire logic [ASRC_DATA_W-1:0] host_data,
   input wire logic host_oe_n,
   // Resolved byte lines and drive state
   output logic [ASRC_DATA_W-1:0] byte_lines,
   output logic drv
);
   logic [ASRC_DATA_W-1:0] mem [ASRC_DEPTH];
   logic sel;
   logic wr;
   assign sel = !pins.select_active_low && pins.select_active_high;
   assign wr = sel && !pins.write_strobe_n;
   assign drv = sel && pins.write_strobe_n && !pins.output_gate_n;
   ////////////////////////////////////////////////////////////////////
   always @*
   begin
      if (wr)
         mem[pins.addr] = host_data;
   end
   // Floating lines show the inverse, so stale data never passes
   always @*
   begin
      if (host_oe_n === 1'b0)
         byte_lines = host_data;
      else if (drv)
         byte_lines = mem[pins.addr];
      else
         byte_lines = ~mem[pins.addr];
   end
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
   import asrc_pkg::*;
;
   logic sys_clk, nrst, req_valid, req_ready, rdata_valid, byte_lines_oe_n, drv;
   asrc_req_t req;
   asrc_pins_t pins;
   logic [7:0] rdata, byte_lines_in, byte_lines_out;
   int miscompares, checks;
   asrc_host u_dut (.sys_clk(sys_clk), .nrst(nrst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
      .rdata(rdata), .rdata_valid(rdata_valid), .pins(pins), .byte_lines_in(byte_lines_in),
      .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n));
   asrc_sram_model u_mem (.pins(pins), .host_data(byte_lines_out), .host_oe_n(byte_lines_oe_n),
      .byte_lines(byte_lines_in), .drv(drv));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("miscompares=%0d checks=%0d", miscompares, checks);
      if (miscompares == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Contention on the shared lines
   always @(negedge sys_clk)
   begin
      if (nrst === 1'b1 && byte_lines_oe_n === 1'b0 && drv === 1'b1)
         chk(drv, 1'h0);
   end
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req = {1'b1, a, d};
      req_valid = 1'b1;
      @(posedge sys_clk);
      #1 req_valid = 1'b0;
      // Strobe falls on the taking edge, so look before each wait
      repeat (5)
      begin
         if (pins.write_strobe_n === 1'b0)
         begin
            n++;
            chk({pins.select_active_low, pins.select_active_high, pins.addr, byte_lines_in, drv, req_ready},
               {2'h1, a, d, 2'h0});
         end
         @(posedge sys_clk);
         #1;
      end
      chk(n >= ASRC_WE_CYC, 1'h1);
      chk(drv, 1'h0);
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] e);
      int k;
      chk(req_ready, 1'h1);
      req = {1'b0, a, 8'h00};
      req_valid = 1'b1;
      @(posedge sys_clk);
      #1 req_valid = 1'b0;
      k = 0;
      while (rdata_valid !== 1'b1 && k < 12)
      begin
         if (pins.select_active_high === 1'b1)
            chk({pins.write_strobe_n, pins.output_gate_n, drv, req_ready}, 4'hA);
         @(posedge sys_clk);
         #1;
         k++;
      end
      if (k == 12)
      begin
         miscompares++;
         test_done;
      end
      chk(rdata, e);
      repeat (3) @(posedge sys_clk);
      #1;
      chk(drv, 1'h0);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      nrst = 1'b0;
      req_valid = 1'b0;
      req = '0;
      miscompares = 0;
      checks = 0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk({pins.select_active_low, pins.select_active_high, pins.write_strobe_n, pins.output_gate_n, byte_lines_oe_n}, 5'h17);
      nrst = 1'b1;
      // Both address ends and the top bit, back to back
      wr(13'h0000, 8'hA5);
      wr(13'h1FFF, 8'h5A);
      wr(13'h1000, 8'h3C);
      rd(13'h0000, 8'hA5);
      rd(13'h1FFF, 8'h5A);
      rd(13'h1000, 8'h3C);
      wr(13'h0000, 8'hC3);
      rd(13'h0000, 8'hC3);
      test_done;
   end
endmodule
`default_nettype wire
